/* File: logic/ptw_pkg.sv */
// Package: entry layout, fault codes, access codes and register map of the table walker
`default_nettype none
package ptw_pkg;

  // ==========================================================================
  // Table entry field positions
  localparam int PFN_LSB      = 32;
  localparam int PFN_W        = 32;
  localparam int UWP_BIT      = 13;
  localparam int KWP_BIT      = 12;
  localparam int URP_BIT      = 9;
  localparam int KRP_BIT      = 8;
  localparam int HINT_LSB     = 5;
  localparam int HINT_W       = 2;
  localparam int MATCH_BIT    = 4;
  localparam int EXEC_TRAP    = 3;
  localparam int WRITE_TRAP   = 2;
  localparam int READ_TRAP    = 1;
  localparam int VALID_BIT    = 0;
  localparam int ENTRY_SHIFT  = 3;

  // ==========================================================================
  // Fault type codes
  localparam logic [2:0] FLT_NOT_VALID = 3'h0;
  localparam logic [2:0] FLT_ACC_VIOL  = 3'h1;
  localparam logic [2:0] FLT_READ      = 3'h2;
  localparam logic [2:0] FLT_EXEC      = 3'h3;
  localparam logic [2:0] FLT_WRITE     = 3'h4;

  // ==========================================================================
  // Access types and segment select
  localparam logic [1:0] ACC_LOAD  = 2'h0;
  localparam logic [1:0] ACC_FETCH = 2'h1;
  localparam logic [1:0] ACC_STORE = 2'h2;
  localparam logic [1:0] SEG_DIRECT = 2'h2;

  // ==========================================================================
  // Register byte offsets and status layout
  localparam logic [7:0] REG_TABLE_BASE = 8'h00;
  localparam logic [7:0] REG_WIN_LO     = 8'h04;
  localparam logic [7:0] REG_WIN_HI     = 8'h08;
  localparam logic [7:0] REG_STATUS     = 8'h0c;
  localparam logic [7:0] REG_EVA_LO     = 8'h10;
  localparam logic [7:0] REG_EVA_HI     = 8'h14;
  localparam int ST_CODE_LSB = 0;
  localparam int ST_FAULTED  = 3;
  localparam int ST_BUSY     = 4;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage : ptw_pkg
`default_nettype wire

/* File: logic/ptw_if.sv */
// Interface: links the walker core with its protection checker and register slave
`timescale 1ns/1ns
`default_nettype none
interface ptw_if;
  logic [63:0] entry;
  logic        user_mode;
  logic [1:0]  access;
  logic        chk_fault;
  logic [2:0]  chk_code;
  logic [31:0] table_base;
  logic [63:0] window_base;
  logic [2:0]  fault_type_code;
  logic        faulted;
  logic        busy;
  logic [63:0] entry_va;

  modport core (output entry, user_mode, access, faulted, busy, fault_type_code, entry_va,
                input  chk_fault, chk_code, table_base, window_base);
  modport chk  (input  entry, user_mode, access, output chk_fault, chk_code);
  modport cfg  (input  faulted, busy, fault_type_code, entry_va, output table_base, window_base);
endinterface : ptw_if
`default_nettype wire

/* File: logic/ptw_prot_check.sv */
// Protection checker for the third-level table entry
`timescale 1ns/1ns
`default_nettype none
module ptw_prot_check (
  ptw_if.chk c
);
  logic is_store;
  logic permit;

  always_comb begin
    // Loads and fetches count as reads, stores as writes
    is_store = (c.access == ptw_pkg::ACC_STORE);
    if (c.user_mode) begin
      permit = is_store ? c.entry[ptw_pkg::UWP_BIT] : c.entry[ptw_pkg::URP_BIT];
    end else begin
      permit = is_store ? c.entry[ptw_pkg::KWP_BIT] : c.entry[ptw_pkg::KRP_BIT];
    end
    c.chk_fault = 1'b1;
    // Permission first, valid flag second, trap bits last
    if (!permit) begin
      c.chk_code = ptw_pkg::FLT_ACC_VIOL;
    end else if (!c.entry[ptw_pkg::VALID_BIT]) begin
      c.chk_code = ptw_pkg::FLT_NOT_VALID;
    end else if (is_store && c.entry[ptw_pkg::WRITE_TRAP]) begin
      c.chk_code = ptw_pkg::FLT_WRITE;
    end else if (c.access == ptw_pkg::ACC_LOAD && c.entry[ptw_pkg::READ_TRAP]) begin
      c.chk_code = ptw_pkg::FLT_READ;
    end else if (c.access == ptw_pkg::ACC_FETCH && c.entry[ptw_pkg::EXEC_TRAP]) begin
      c.chk_code = ptw_pkg::FLT_EXEC;
    end else begin
      c.chk_fault = 1'b0;
      c.chk_code  = ptw_pkg::FLT_NOT_VALID;
    end
  end
endmodule : ptw_prot_check
`default_nettype wire

/* File: logic/ptw_regs.sv */
// Wishbone classic register slave for the table walker
`timescale 1ns/1ns
`default_nettype none
module ptw_regs (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  ptw_if.cfg               c
);
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [31:0] tbase;
    logic [63:0] wbase;
  } ptw_reg_state_t;

  ptw_reg_state_t s, next_s;

  function automatic logic [31:0] ptw_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : ptw_merge

  always_comb begin
    next_s = s;
    // Ack one cycle after the request; dropped the cycle after
    next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
    next_s.rdata = ptw_pkg::RST_WORD;
    case (wb_adr_i)
      ptw_pkg::REG_TABLE_BASE: next_s.rdata = s.tbase;
      ptw_pkg::REG_WIN_LO:     next_s.rdata = s.wbase[31:0];
      ptw_pkg::REG_WIN_HI:     next_s.rdata = s.wbase[63:32];
      ptw_pkg::REG_STATUS: begin
        next_s.rdata[ptw_pkg::ST_CODE_LSB +: 3] = c.fault_type_code;
        next_s.rdata[ptw_pkg::ST_FAULTED]       = c.faulted;
        next_s.rdata[ptw_pkg::ST_BUSY]          = c.busy;
      end
      ptw_pkg::REG_EVA_LO:     next_s.rdata = c.entry_va[31:0];
      ptw_pkg::REG_EVA_HI:     next_s.rdata = c.entry_va[63:32];
      default:                 next_s.rdata = ptw_pkg::RST_WORD;
    endcase
    // Writes land on the edge where the master sees ack
    if (wb_cyc_i && wb_stb_i && wb_we_i && s.ack) begin
      case (wb_adr_i)
        ptw_pkg::REG_TABLE_BASE: next_s.tbase = ptw_merge(s.tbase, wb_dat_i, wb_sel_i);
        ptw_pkg::REG_WIN_LO:     next_s.wbase[31:0] = ptw_merge(s.wbase[31:0], wb_dat_i, wb_sel_i);
        ptw_pkg::REG_WIN_HI:     next_s.wbase[63:32] = ptw_merge(s.wbase[63:32], wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o      = s.ack;
  assign wb_dat_o      = s.rdata;
  assign c.table_base  = s.tbase;
  assign c.window_base = s.wbase;
endmodule : ptw_regs
`default_nettype wire

/* File: logic/ptw_walker.sv */
// Top: three-level table walker with protection checks and a register slave
//
// Functional notes
// - Valid entry: frame number joins page offset
// - Software and reserved entry bits are ignored
// - User store needs user write permit
// - Kernel store needs kernel write permit
// - User read or fetch needs user read permit
// - Kernel read or fetch needs kernel read permit
// - Block size hint reported with finished translation
// - Match-all-spaces bit reported for translation buffer
// - Trap bits fault execute, write, read accesses
// - Valid flag only qualifies the frame number
// - Walker never writes table entries
// - Each entry fetched by one quadword read
// - Invalid entries are never handed out cached
// - Direct segment: kernel read/write, user none
// - Loads and fetches are reads, stores writes
// - Mode bit one is user, zero kernel
// - Non sign-extended address is access violation
// - Entry address is base frame plus eight index
// - Invalid upper entry: violation or not-valid
// - Valid upper entries' protection bits are ignored
// - Last level: permission, valid, then trap bits
// - Window address of last-level entry is formed
// - Fault codes zero through four reported
// - Direct segment bypasses tables, sign-extended
`timescale 1ns/1ns
`default_nettype none
module ptw_walker #(
  parameter int VA_BITS   = 43,
  parameter int PAGE_BITS = 13,
  parameter int LVL_BITS  = 10
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Translation request
  input  wire logic        tr_req,
  input  wire logic [63:0] tr_va,
  input  wire logic [1:0]  tr_access,
  input  wire logic        status_mode_bit,
  output logic             tr_busy,
  output logic             tr_done,
  output logic             tr_fault,
  output logic      [2:0]  fault_type_code,
  output logic      [63:0] phys_addr,
  output logic      [1:0]  block_size_hint,
  output logic             match_all_spaces,
  // Table memory read port
  output logic             mem_rd_req,
  output logic      [63:0] mem_rd_addr,
  input  wire logic        mem_rd_ack,
  input  wire logic [63:0] mem_rd_data,
  // Register bus
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  localparam int WIN_KEEP = 4 * PAGE_BITS - 9;

  typedef enum logic [1:0] { PTW_IDLE, PTW_WALK, PTW_CHECK } ptw_state_t;

  typedef struct packed {
    ptw_state_t  st;
    logic        busy;
    logic [1:0]  lvl;
    logic [63:0] va;
    logic [1:0]  access;
    logic        user;
    logic [63:0] entry;
    logic        req;
    logic [63:0] addr;
    logic        done;
    logic        fault;
    logic [2:0]  code;
    logic        faulted;
    logic [63:0] pa;
    logic [1:0]  hint;
    logic        match;
    logic [63:0] eva;
  } ptw_core_state_t;

  ptw_core_state_t s, next_s;
  ptw_if           pif ();

  // ==========================================================================
  // Helpers
  function automatic logic [63:0] ptw_mask(input int bits);
    return (64'h1 << bits) - 64'h1;
  endfunction : ptw_mask

  function automatic logic ptw_sext_ok(input logic [63:0] va);
    logic [63:0] hi;
    hi = va & ~ptw_mask(VA_BITS - 1);
    return (hi == 64'h0) || (hi == ~ptw_mask(VA_BITS - 1));
  endfunction : ptw_sext_ok

  function automatic logic [LVL_BITS-1:0] ptw_index(input logic [63:0] va, input logic [1:0] lvl);
    // Level one is the highest index field
    return va[PAGE_BITS + (3 - int'(lvl)) * LVL_BITS +: LVL_BITS];
  endfunction : ptw_index

  function automatic logic [63:0] ptw_entry_addr(input logic [31:0] pfn, input logic [LVL_BITS-1:0] idx);
    return (64'(pfn) << PAGE_BITS) + (64'(idx) << ptw_pkg::ENTRY_SHIFT);
  endfunction : ptw_entry_addr

  function automatic logic [31:0] ptw_pfn(input logic [63:0] e);
    return e[ptw_pkg::PFN_LSB +: ptw_pkg::PFN_W];
  endfunction : ptw_pfn

  // ==========================================================================
  // Submodules
  ptw_prot_check u_chk (
    .c (pif.chk)
  );

  ptw_regs u_regs (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .c        (pif.cfg)
  );

  assign pif.entry           = s.entry;
  assign pif.user_mode       = s.user;
  assign pif.access          = s.access;
  assign pif.faulted         = s.faulted;
  assign pif.busy            = s.busy;
  assign pif.fault_type_code = s.code;
  assign pif.entry_va        = s.eva;

  // ==========================================================================
  // Walk sequencer
  always_comb begin
    logic [63:0] e;
    logic [63:0] wva;
    e = mem_rd_data;
    wva = '0;
    next_s = s;
    // Answer strobes last one cycle
    next_s.done  = 1'b0;
    next_s.fault = 1'b0;
    case (s.st)
      PTW_IDLE: begin
        if (tr_req) begin
          next_s.va     = tr_va;
          next_s.access = tr_access;
          next_s.user   = status_mode_bit;
          // Window address of the last-level entry, kept for table fills
          wva = (tr_va & ptw_mask(WIN_KEEP)) >> (PAGE_BITS - ptw_pkg::ENTRY_SHIFT);
          wva = pif.window_base | wva;
          wva[2:0] = 3'h0;
          next_s.eva = wva;
          if (!ptw_sext_ok(tr_va)) begin
            next_s.fault   = 1'b1;
            next_s.faulted = 1'b1;
            next_s.code    = ptw_pkg::FLT_ACC_VIOL;
          end else if (tr_va[VA_BITS-1 -: 2] == ptw_pkg::SEG_DIRECT) begin
            if (status_mode_bit) begin
              next_s.fault   = 1'b1;
              next_s.faulted = 1'b1;
              next_s.code    = ptw_pkg::FLT_ACC_VIOL;
            end else begin
              // No table lookup; sign-extend the low bits
              next_s.done  = 1'b1;
              next_s.pa    = tr_va[VA_BITS-3] ? (tr_va | ~ptw_mask(VA_BITS - 2))
                                              : (tr_va & ptw_mask(VA_BITS - 2));
              next_s.hint  = 2'h0;
              next_s.match = 1'b0;
            end
          end else begin
            next_s.st   = PTW_WALK;
            next_s.lvl  = 2'h1;
            next_s.req  = 1'b1;
            next_s.addr = ptw_entry_addr(pif.table_base, ptw_index(tr_va, 2'h1));
          end
        end
      end
      PTW_WALK: begin
        // One quadword read per level, data used only in the cycle of its ack
        if (mem_rd_ack) begin
          next_s.req = 1'b0;
          if (s.lvl == 2'h3) begin
            next_s.entry = e;
            next_s.st    = PTW_CHECK;
          end else if (!e[ptw_pkg::VALID_BIT]) begin
            next_s.st      = PTW_IDLE;
            next_s.fault   = 1'b1;
            next_s.faulted = 1'b1;
            next_s.code    = e[ptw_pkg::KRP_BIT] ? ptw_pkg::FLT_NOT_VALID : ptw_pkg::FLT_ACC_VIOL;
          end else begin
            // Protection bits of a valid upper entry play no part
            next_s.lvl  = s.lvl + 2'h1;
            next_s.req  = 1'b1;
            next_s.addr = ptw_entry_addr(ptw_pfn(e), ptw_index(s.va, s.lvl + 2'h1));
          end
        end
      end
      PTW_CHECK: begin
        next_s.st = PTW_IDLE;
        if (pif.chk_fault) begin
          next_s.fault   = 1'b1;
          next_s.faulted = 1'b1;
          next_s.code    = pif.chk_code;
        end else begin
          // Only a valid entry reaches here, so nothing invalid is handed out
          next_s.done  = 1'b1;
          next_s.pa    = (64'(ptw_pfn(s.entry)) << PAGE_BITS) | (s.va & ptw_mask(PAGE_BITS));
          next_s.hint  = s.entry[ptw_pkg::HINT_LSB +: ptw_pkg::HINT_W];
          next_s.match = s.entry[ptw_pkg::MATCH_BIT];
        end
      end
      default: begin
        next_s.st  = PTW_IDLE;
        next_s.req = 1'b0;
      end
    endcase
    // Busy kept in its own flop so the port carries no decode
    next_s.busy = (next_s.st != PTW_IDLE);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs; the memory port is read-only by construction
  assign tr_busy          = s.busy;
  assign tr_done          = s.done;
  assign tr_fault         = s.fault;
  assign fault_type_code  = s.code;
  assign phys_addr        = s.pa;
  assign block_size_hint  = s.hint;
  assign match_all_spaces = s.match;
  assign mem_rd_req       = s.req;
  assign mem_rd_addr      = s.addr;

endmodule : ptw_walker
`default_nettype wire

/* File: test/ptw_walker_sva.sv */
// Concurrent checks on the table walker top ports
`timescale 1ns/1ns
`default_nettype none
module ptw_walker_sva #(
  parameter int VA_BITS   = 43,
  parameter int PAGE_BITS = 13
) (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        tr_req,
  input wire logic [63:0] tr_va,
  input wire logic        status_mode_bit,
  input wire logic        tr_busy,
  input wire logic        tr_done,
  input wire logic        tr_fault,
  input wire logic [2:0]  fault_type_code,
  input wire logic [63:0] phys_addr,
  input wire logic        mem_rd_req,
  input wire logic [63:0] mem_rd_addr,
  input wire logic        mem_rd_ack
);
  // ==========
  // Helpers
  logic [63:0] va_q;
  logic        take;
  logic        sext_ok;
  assign take    = tr_req && !tr_busy;
  assign sext_ok = (&tr_va[63:VA_BITS-1]) || !(|tr_va[63:VA_BITS-1]);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      va_q <= 64'h0;
    else if (take)
      va_q <= tr_va;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ==========
  // Assertions
  a_answer_exclusive: assert property (!(tr_done && tr_fault)) else $error("done and fault together");
  a_done_single: assert property (tr_done |=> !tr_done) else $error("done longer than one cycle");
  a_fault_single: assert property (tr_fault |=> !tr_fault) else $error("fault longer than one cycle");
  a_read_holds: assert property (mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr))
    else $error("table read dropped or moved before ack");
  a_read_ends: assert property (mem_rd_req && mem_rd_ack |=> !(mem_rd_req && $stable(mem_rd_addr)))
    else $error("same entry read twice");
  a_entry_aligned: assert property (mem_rd_req |-> mem_rd_addr[2:0] == 3'h0) else $error("entry unaligned");
  a_idle_no_read: assert property (!tr_busy |-> !mem_rd_req) else $error("table read while idle");
  a_walk_bounded: assert property ($rose(tr_busy) |-> ##[1:1000] (tr_done || tr_fault))
    else $error("walk never answered");
  a_offset_kept: assert property (tr_done |-> phys_addr[PAGE_BITS-1:0] == va_q[PAGE_BITS-1:0])
    else $error("page offset not passed through");
  a_code_range: assert property (tr_fault |-> fault_type_code <= 3'h4) else $error("fault code out of range");
  a_sext_fault: assert property (take && !sext_ok |-> ##[1:2] (tr_fault && fault_type_code == 3'h1))
    else $error("bad sign extension not refused");
  a_user_direct: assert property (take && sext_ok && tr_va[VA_BITS-1 -: 2] == 2'h2 && status_mode_bit
    |-> ##[1:2] (tr_fault && fault_type_code == 3'h1)) else $error("user reached direct segment");
endmodule : ptw_walker_sva
bind ptw_walker ptw_walker_sva #(.VA_BITS(VA_BITS), .PAGE_BITS(PAGE_BITS)) u_sva (
  .core_clk(core_clk), .arst_n(arst_n), .tr_req(tr_req), .tr_va(tr_va), .status_mode_bit(status_mode_bit),
  .tr_busy(tr_busy), .tr_done(tr_done), .tr_fault(tr_fault), .fault_type_code(fault_type_code),
  .phys_addr(phys_addr), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack));
`default_nettype wire

/* File: test/ptw_mem_model.sv */
// Table memory model answering quadword reads after a set latency
`timescale 1ns/1ns
`default_nettype none
module ptw_mem_model (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic [3:0]  lat,
  input wire logic        mem_rd_req,
  input wire logic [63:0] mem_rd_addr,
  output logic            mem_rd_ack,
  output logic     [63:0] mem_rd_data
);
  logic [63:0] store [logic [63:0]];
  logic [3:0]  wait_cnt;
  // Data is only good with ack; otherwise it toggles so a late sample shows up
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_rd_ack  <= 1'h0;
      mem_rd_data <= 64'h0;
      wait_cnt    <= 4'h0;
    end else if (mem_rd_req && !mem_rd_ack && wait_cnt >= lat) begin
      mem_rd_ack  <= 1'h1;
      mem_rd_data <= store.exists(mem_rd_addr) ? store[mem_rd_addr] : 64'h0;
      wait_cnt    <= 4'h0;
    end else begin
      mem_rd_ack  <= 1'h0;
      mem_rd_data <= ~mem_rd_data;
      if (mem_rd_req && !mem_rd_ack)
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : ptw_mem_model
`default_nettype wire

/* File: test/ptw_walker_tb_top.sv */
// Testbench for the table walker: walks, protection faults, direct segment, registers
`timescale 1ns/1ns
`default_nettype none
module ptw_walker_tb_top;
  localparam logic [63:0] VA  = 64'h0000_0006_0280_e123;
  localparam logic [63:0] PA  = 64'h0000_0000_1579_a123;
  localparam logic [63:0] L1A = 64'h2_0018;
  localparam logic [63:0] L2A = 64'h4_0028;
  localparam logic [1:0]  LD  = ptw_pkg::ACC_LOAD;
  localparam logic [1:0]  FE  = ptw_pkg::ACC_FETCH;
  localparam logic [1:0]  ST  = ptw_pkg::ACC_STORE;
  logic        core_clk, arst_n, tr_req, status_mode_bit, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [63:0] tr_va;
  logic [1:0]  tr_access;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, lat;
  logic [31:0] wb_dat_i, rd;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, tr_busy, tr_done, tr_fault, match_all_spaces, mem_rd_req, mem_rd_ack;
  wire  [2:0]  fault_type_code;
  wire  [1:0]  block_size_hint;
  wire  [63:0] phys_addr, mem_rd_addr, mem_rd_data;
  int          num_errors, checked;

  ptw_walker #(.VA_BITS(43), .PAGE_BITS(13), .LVL_BITS(10)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .tr_req(tr_req), .tr_va(tr_va), .tr_access(tr_access),
    .status_mode_bit(status_mode_bit), .tr_busy(tr_busy), .tr_done(tr_done), .tr_fault(tr_fault),
    .fault_type_code(fault_type_code), .phys_addr(phys_addr), .block_size_hint(block_size_hint),
    .match_all_spaces(match_all_spaces), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  ptw_mem_model mem (.core_clk(core_clk), .arst_n(arst_n), .lat(lat), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data));

  always #20 core_clk = ~core_clk;

  // ==========
  // Tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (n >= 20)
      num_errors++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge core_clk);
  endtask : wb_xfer

  task automatic wb_check(input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'h0, adr, 32'h0);
    check({32'h0, rd}, {32'h0, exp});
  endtask : wb_check

  // Answer may land on the take edge or later, so look right after it
  task automatic xlate(input logic [63:0] va, input logic mode, input logic [1:0] acc,
                       input logic flt, input logic [63:0] exp);
    int n;
    tr_req <= 1'h1;
    tr_va <= va;
    status_mode_bit <= mode;
    tr_access <= acc;
    @(posedge core_clk);
    tr_req <= 1'h0;
    n = 0;
    #1;
    while (tr_done !== 1'h1 && tr_fault !== 1'h1 && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 200)
      num_errors++;
    check({63'h0, tr_fault}, {63'h0, flt});
    check(flt ? {61'h0, fault_type_code} : phys_addr, exp);
    check({63'h0, tr_done}, {63'h0, ~flt});
    check({63'h0, tr_busy}, 64'h0);
    @(posedge core_clk);
  endtask : xlate

  task automatic leaf(input logic [31:0] low, input logic mode, input logic [1:0] acc,
                      input logic flt, input logic [63:0] exp);
    mem.store[64'h6_0038] = {32'h0000_abcd, low};
    xlate(VA, mode, acc, flt, exp);
  endtask : leaf

  task automatic report_and_stop;
    $display("Comparisons %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========
  // Sequence
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    core_clk = 1'h0; arst_n = 1'h0; tr_req = 1'h0; tr_va = 64'h0; tr_access = 2'h0; status_mode_bit = 1'h0;
    wb_cyc_i = 1'h0; wb_stb_i = 1'h0; wb_we_i = 1'h0; wb_adr_i = 8'h0; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
    lat = 4'h0; num_errors = 0; checked = 0;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'h1;
    @(posedge core_clk);
    wb_check(ptw_pkg::REG_STATUS, 32'h0);
    wb_xfer(1'h1, ptw_pkg::REG_TABLE_BASE, 32'h10);
    wb_check(ptw_pkg::REG_TABLE_BASE, 32'h10);
    wb_xfer(1'h1, ptw_pkg::REG_WIN_HI, 32'h100);
    wb_xfer(1'h1, ptw_pkg::REG_STATUS, 32'h1f);
    wb_check(ptw_pkg::REG_STATUS, 32'h0);
    wb_check(8'h20, 32'h0);
    // First-level entry valid without kernel read permit: protection must be ignored
    mem.store[L1A] = 64'h0000_0020_0000_0001;
    mem.store[L2A] = 64'h0000_0030_0000_0101;
    leaf(32'h3371, 1'h0, LD, 1'h0, PA);
    check({62'h0, block_size_hint}, 64'h3);
    check({63'h0, match_all_spaces}, 64'h1);
    leaf(32'hffff_3301, 1'h0, LD, 1'h0, PA);
    leaf(32'h3301, 1'h1, ST, 1'h0, PA);
    leaf(32'h1301, 1'h1, ST, 1'h1, 64'h1);
    leaf(32'h2301, 1'h0, ST, 1'h1, 64'h1);
    leaf(32'h3101, 1'h1, FE, 1'h1, 64'h1);
    leaf(32'h3201, 1'h0, LD, 1'h1, 64'h1);
    leaf(32'h1300, 1'h1, ST, 1'h1, 64'h1);
    leaf(32'h3300, 1'h0, LD, 1'h1, 64'h0);
    leaf(32'h330b, 1'h0, FE, 1'h1, 64'h3);
    leaf(32'h3303, 1'h0, LD, 1'h1, 64'h2);
    leaf(32'h3305, 1'h1, ST, 1'h1, 64'h4);
    leaf(32'h3304, 1'h0, ST, 1'h1, 64'h0);
    mem.store[L1A] = 64'h0000_0020_0000_0100;
    xlate(VA, 1'h1, LD, 1'h1, 64'h0);
    mem.store[L1A] = 64'h0000_0020_0000_0000;
    xlate(VA, 1'h0, LD, 1'h1, 64'h1);
    mem.store[L1A] = 64'h0000_0020_0000_0001;
    mem.store[L2A] = 64'h0000_0030_0000_0000;
    xlate(VA, 1'h0, ST, 1'h1, 64'h1);
    mem.store[L2A] = 64'h0000_0030_0000_0101;
    lat <= 4'h3;
    leaf(32'h3301, 1'h1, LD, 1'h0, PA);
    lat <= 4'h0;
    wb_check(ptw_pkg::REG_EVA_LO, 32'h0180_a038);
    wb_check(ptw_pkg::REG_EVA_HI, 32'h0000_0100);
    xlate(64'hffff_fc00_0001_2345, 1'h0, ST, 1'h0, 64'h1_2345);
    xlate(64'hffff_fd00_0000_0010, 1'h0, LD, 1'h0, 64'hffff_ff00_0000_0010);
    xlate(64'hffff_fc00_0001_2345, 1'h1, FE, 1'h1, 64'h1);
    xlate(64'h0000_0400_0000_0000, 1'h0, LD, 1'h1, 64'h1);
    wb_check(ptw_pkg::REG_STATUS, 32'h9);
    report_and_stop();
  end
endmodule : ptw_walker_tb_top
`default_nettype wire
